// File: pkg/sfd_pkg.sv
// constants and word layouts for the synthesizer divider control block
// assumes words arrive lsb first over a three-wire serial port
package sfd_pkg;
	localparam int WORD_W = 24;
	localparam int DATA_W = 22;
	localparam int ADDR_HI = 23;
	localparam int ADDR_LO = 22;
	localparam int CNT_W = 11;
	localparam int SWL_W = 5;
	localparam int SPD_W = 6;
	localparam int SPC_W = 7;
	localparam int NLOOP = 3;
	// word addresses
	localparam logic [1:0] ADDR_MAIN = 2'h0;
	localparam logic [1:0] ADDR_AUX1 = 2'h1;
	localparam logic [1:0] ADDR_AUX2 = 2'h2;
	localparam logic [1:0] ADDR_CTRL = 2'h3;
	// loop indices
	localparam int L_MAIN = 0;
	localparam int L_AUX1 = 1;
	localparam int L_AUX2 = 2;
	// lock selector codes
	localparam logic [1:0] LK_MAIN = 2'h0;
	localparam logic [1:0] LK_AUX1 = 2'h1;
	localparam logic [1:0] LK_AUX2 = 2'h2;
	localparam logic [1:0] LK_AND = 2'h3;
	// reset value of every operational word
	localparam logic [DATA_W-1:0] WORD_RST = 22'h000000;

	// fields listed msb first, as they sit in the word
	typedef struct packed {
		logic [5:0]  speedup;
		logic [10:0] counter_value;
		logic [4:0]  swallow_value;
	} sfd_main_t;

	typedef struct packed {
		logic [5:0]  aux_speedup;
		logic [1:0]  main_ratio;
		logic [10:0] counter_value;
		logic [2:0]  swallow_value;
	} sfd_aux1_t;

	typedef struct packed {
		logic [1:0]  post_aux2;
		logic [1:0]  post_aux1;
		logic [1:0]  post_main;
		logic [1:0]  aux_ratio;
		logic [10:0] counter_value;
		logic [2:0]  swallow_value;
	} sfd_aux2_t;

	typedef struct packed {
		logic [5:0]  test_route;
		logic [1:0]  lock_sel;
		logic        en_aux2;
		logic        en_aux1;
		logic        en_main;
		logic [10:0] ref_div;
	} sfd_ctrl_t;
endpackage

// File: design/sfd_top.sv
// serial load port, dividers, speed-up timers and lock select
// assumes all pins (serial port, reference, prescalers, lock) are async
`timescale 1ns/1ps

module sfd_top (
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	input  wire logic       ser_clk_i,
	input  wire logic       ser_data_i,
	input  wire logic       ser_strobe_i,
	input  wire logic       external_reference_oscillator_i,
	input  wire logic [2:0] prescaler_i,
	input  wire logic [2:0] loop_lock_i,
	output logic      [2:0] modulus_o,
	output logic      [2:0] div_out_o,
	output logic      [2:0] pd_ref_o,
	output logic      [2:0] speedup_o,
	output logic      [2:0] power_en_o,
	output logic      [1:0] main_ratio_o,
	output logic      [1:0] aux_ratio_o,
	output logic      [5:0] test_route_o,
	output logic            lock_indicator_output_o
);
	localparam int W = sfd_pkg::WORD_W;
	localparam int CW = sfd_pkg::CNT_W;
	localparam int SW = sfd_pkg::SWL_W;
	localparam int PW = sfd_pkg::SPC_W;

	////////////////////////////////////////////////////////////////////
	// pin synchronisers: stage one feeds stage two only
	logic [7:0] sync1;
	logic [7:0] sync2;
	logic [7:0] prev;
	logic [7:0] pins;

	assign pins = {loop_lock_i, prescaler_i, external_reference_oscillator_i,
		ser_strobe_i};

	// two flops, then an edge-history flop
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sync1 <= 8'h00;
			sync2 <= 8'h00;
			prev  <= 8'h00;
		end
		else
		begin
			sync1 <= pins;
			sync2 <= sync1;
			prev  <= sync2;
		end
	end

	logic [1:0] ser_s1;
	logic [1:0] ser_s2;
	logic       sclk_prev;

	// serial clock and data sampled together
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ser_s1    <= 2'h0;
			ser_s2    <= 2'h0;
			sclk_prev <= 1'b0;
		end
		else
		begin
			ser_s1    <= {ser_clk_i, ser_data_i};
			ser_s2    <= ser_s1;
			sclk_prev <= ser_s2[1];
		end
	end

	logic       sclk_rise;
	logic       strobe_rise;
	logic       ref_rise;
	logic [2:0] pre_rise;
	logic [2:0] lock_s;

	assign sclk_rise   = ser_s2[1] & ~sclk_prev;
	assign strobe_rise = sync2[0] & ~prev[0];
	assign ref_rise    = sync2[1] & ~prev[1];
	assign pre_rise    = sync2[4:2] & ~prev[4:2];
	assign lock_s      = sync2[7:5];

	////////////////////////////////////////////////////////////////////
	// holding shift register and operational words
	logic [W-1:0]             shift;
	logic [W-1:0]             next_shift;
	logic [sfd_pkg::DATA_W-1:0] op [4];
	logic [sfd_pkg::DATA_W-1:0] next_op [4];
	logic [1:0]               waddr;
	logic                     main_trig;
	logic [2:0]               aux_trig;

	assign waddr = shift[sfd_pkg::ADDR_HI:sfd_pkg::ADDR_LO];

	// shift and commit; only the addressed word moves
	always_comb
	begin
		next_shift = shift;
		for (int k = 0; k < 4; k++)
			next_op[k] = op[k];
		if (sclk_rise)
			next_shift = {ser_s2[0], shift[W-1:1]};
		if (strobe_rise)
			next_op[waddr] = shift[sfd_pkg::DATA_W-1:0];
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			shift <= 24'h000000;
			for (int k = 0; k < 4; k++)
				op[k] <= sfd_pkg::WORD_RST;
		end
		else
		begin
			shift <= next_shift;
			for (int k = 0; k < 4; k++)
				op[k] <= next_op[k];
		end
	end

	// field views, msb first after the address
	sfd_pkg::sfd_main_t w_main;
	sfd_pkg::sfd_aux1_t w_aux1;
	sfd_pkg::sfd_aux2_t w_aux2;
	sfd_pkg::sfd_ctrl_t w_ctrl;
	sfd_pkg::sfd_ctrl_t new_ctrl;

	assign w_main   = op[sfd_pkg::ADDR_MAIN];
	assign w_aux1   = op[sfd_pkg::ADDR_AUX1];
	assign w_aux2   = op[sfd_pkg::ADDR_AUX2];
	assign w_ctrl   = op[sfd_pkg::ADDR_CTRL];
	assign new_ctrl = shift[sfd_pkg::DATA_W-1:0];

	// speed-up triggers; aux fires only on an enable rising
	assign main_trig = strobe_rise & (waddr == sfd_pkg::ADDR_MAIN);
	assign aux_trig[sfd_pkg::L_MAIN] = 1'b0;
	assign aux_trig[sfd_pkg::L_AUX1] = strobe_rise
		& (waddr == sfd_pkg::ADDR_CTRL)
		& new_ctrl.en_aux1 & ~w_ctrl.en_aux1;
	assign aux_trig[sfd_pkg::L_AUX2] = strobe_rise
		& (waddr == sfd_pkg::ADDR_CTRL)
		& new_ctrl.en_aux2 & ~w_ctrl.en_aux2;

	////////////////////////////////////////////////////////////////////
	// reference divider, shared by all loops
	logic [CW-1:0] rcnt;
	logic [CW-1:0] next_rcnt;
	logic          rtick;
	logic          next_rtick;

	// zero is treated as divide-by-one rather than stalling
	always_comb
	begin
		next_rcnt  = rcnt;
		next_rtick = 1'b0;
		if (ref_rise)
		begin
			if (rcnt + 11'h001 >= w_ctrl.ref_div)
			begin
				next_rcnt  = 11'h000;
				next_rtick = 1'b1;
			end
			else
				next_rcnt = rcnt + 11'h001;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rcnt  <= 11'h000;
			rtick <= 1'b0;
		end
		else
		begin
			rcnt  <= next_rcnt;
			rtick <= next_rtick;
		end
	end

	////////////////////////////////////////////////////////////////////
	// per-loop settings
	logic [CW-1:0] set_n   [3];
	logic [SW-1:0] set_a   [3];
	logic [1:0]    set_ps  [3];
	logic [5:0]    set_spd [3];
	logic [2:0]    en;

	assign en = {w_ctrl.en_aux2, w_ctrl.en_aux1, w_ctrl.en_main};
	assign set_n[0]   = w_main.counter_value;
	assign set_a[0]   = w_main.swallow_value;
	assign set_n[1]   = w_aux1.counter_value;
	assign set_a[1]   = {2'h0, w_aux1.swallow_value};
	assign set_n[2]   = w_aux2.counter_value;
	assign set_a[2]   = {2'h0, w_aux2.swallow_value};
	assign set_ps[0]  = w_aux2.post_main;
	assign set_ps[1]  = w_aux2.post_aux1;
	assign set_ps[2]  = w_aux2.post_aux2;
	assign set_spd[0] = w_main.speedup;
	assign set_spd[1] = w_aux1.aux_speedup;
	assign set_spd[2] = w_aux1.aux_speedup;

	////////////////////////////////////////////////////////////////////
	// one divider, postscaler and speed-up timer per loop
	for (genvar i = 0; i < sfd_pkg::NLOOP; i++)
	begin : g_loop
		logic [CW-1:0] act_n, next_act_n, ncnt, next_ncnt;
		logic [SW-1:0] act_a, next_act_a, acnt, next_acnt;
		logic [2:0]    pcnt, next_pcnt;
		logic [PW-1:0] scnt, next_scnt;
		logic          pend, next_pend, tick, next_tick;
		logic          next_div, next_mod;
		logic [2:0]    plim;

		assign plim = 3'((4'h1 << set_ps[i]) - 4'h1);

		// dividers take new settings only at the next reference pulse
		always_comb
		begin
			next_act_n = act_n;
			next_act_a = act_a;
			next_ncnt  = ncnt;
			next_acnt  = acnt;
			next_pcnt  = pcnt;
			next_tick  = 1'b0;
			next_div   = 1'b0;
			next_scnt  = scnt;
			next_pend  = pend | main_trig & (i == 0) | aux_trig[i];
			if (rtick)
			begin
				if (pcnt >= plim)
				begin
					next_pcnt = 3'h0;
					next_tick = 1'b1;
				end
				else
					next_pcnt = pcnt + 3'h1;
			end
			if (tick)
			begin
				next_act_n = set_n[i];
				next_act_a = set_a[i];
				if (pend)
				begin
					next_scnt = {set_spd[i], 1'b0};
					next_pend = main_trig & (i == 0) | aux_trig[i];
				end
				else if (scnt != 7'h00)
					next_scnt = scnt - 7'h01;
			end
			// swallow phase runs at the high modulus
			if (pre_rise[i])
			begin
				if (acnt != 5'h00)
					next_acnt = acnt - 5'h01;
				if (ncnt <= 11'h001)
				begin
					next_ncnt = act_n;
					next_acnt = act_a;
					next_div  = 1'b1;
				end
				else
					next_ncnt = ncnt - 11'h001;
			end
			if (!en[i])
			begin
				next_scnt = 7'h00; // disabled loop holds no speed-up
				// enable is still the old value in the commit cycle
				next_pend = aux_trig[i];
			end
			next_mod = next_acnt != 5'h00;
		end

		always_ff @(posedge clock_i or negedge rstn_i)
		begin
			if (!rstn_i)
			begin
				act_n        <= 11'h000;
				act_a        <= 5'h00;
				ncnt         <= 11'h000;
				acnt         <= 5'h00;
				pcnt         <= 3'h0;
				tick         <= 1'b0;
				scnt         <= 7'h00;
				pend         <= 1'b0;
				modulus_o[i] <= 1'b0;
				div_out_o[i] <= 1'b0;
				pd_ref_o[i]  <= 1'b0;
				speedup_o[i] <= 1'b0;
			end
			else
			begin
				act_n        <= next_act_n;
				act_a        <= next_act_a;
				ncnt         <= next_ncnt;
				acnt         <= next_acnt;
				pcnt         <= next_pcnt;
				tick         <= next_tick;
				scnt         <= next_scnt;
				pend         <= next_pend;
				modulus_o[i] <= next_mod;
				div_out_o[i] <= next_div;
				pd_ref_o[i]  <= next_tick;
				speedup_o[i] <= next_scnt != 7'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// lock select and static outputs
	logic       next_lock;
	logic [2:0] lk_term;

	assign lk_term = lock_s | ~en;

	always_comb
	begin
		case (w_ctrl.lock_sel)
			sfd_pkg::LK_MAIN: next_lock = lock_s[sfd_pkg::L_MAIN];
			sfd_pkg::LK_AUX1: next_lock = lock_s[sfd_pkg::L_AUX1];
			sfd_pkg::LK_AUX2: next_lock = lock_s[sfd_pkg::L_AUX2];
			sfd_pkg::LK_AND:  next_lock = (&lk_term) & (|en);
			default:          next_lock = 1'b0;
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			lock_indicator_output_o <= 1'b0;
			power_en_o              <= 3'h0;
			main_ratio_o            <= 2'h0;
			aux_ratio_o             <= 2'h0;
			test_route_o            <= 6'h00;
		end
		else
		begin
			lock_indicator_output_o <= next_lock;
			power_en_o              <= en;
			main_ratio_o            <= w_aux1.main_ratio;
			aux_ratio_o             <= w_aux2.aux_ratio;
			test_route_o            <= w_ctrl.test_route;
		end
	end
endmodule

// File: dv/sfd_chk.sv
// checker on the divider control ports: commits, pulses, speed-up
// assumes it is bound into sfd_top and sees only its ports
`timescale 1ns/1ps
module sfd_chk (
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	input  wire logic       ser_strobe_i,
	input  wire logic [2:0] div_out_o,
	input  wire logic [2:0] pd_ref_o,
	input  wire logic [2:0] speedup_o,
	input  wire logic [2:0] power_en_o,
	input  wire logic [1:0] main_ratio_o,
	input  wire logic [1:0] aux_ratio_o,
	input  wire logic [5:0] test_route_o
);
	logic [3:0] age;
	logic [3:0] next_age;
	logic       stb_q;
	logic       next_stb_q;

	////////////////////////////////////////
	// clocks since the strobe pin rose; saturates so it never wraps
	always_comb
	begin
		next_age = (age == 4'hf) ? age : age + 4'h1;
		if (ser_strobe_i && !stb_q)
			next_age = 4'h0;
		next_stb_q = ser_strobe_i;
	end

	// plain registers, reset with the design; age starts saturated
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			age   <= 4'hf;
			stb_q <= 1'b0;
		end
		else
		begin
			age   <= next_age;
			stb_q <= next_stb_q;
		end
	end

	////////////////////////////////////////
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);

	// a reference pulse now or up to two cycles before
	sequence s_pd_near(x);
		x || $past(x) || $past(x, 2);
	endsequence

	property p_en_commit;
		$changed(power_en_o) |-> age <= 4'h8;
	endproperty
	a_en_commit: assert property (p_en_commit)
		else $error("enables moved without strobe");
	property p_field_commit;
		$changed({main_ratio_o, aux_ratio_o, test_route_o}) |-> age <= 4'h8;
	endproperty
	a_field_commit: assert property (p_field_commit)
		else $error("fields moved without strobe");
	property p_pd_pulse;
		pd_ref_o[0] |=> !pd_ref_o[0];
	endproperty
	a_pd_pulse: assert property (p_pd_pulse)
		else $error("reference pulse too long");
	property p_div_pulse;
		div_out_o[0] |=> !div_out_o[0];
	endproperty
	a_div_pulse: assert property (p_div_pulse)
		else $error("divider pulse too long");
	property p_main_start;
		$rose(speedup_o[0]) |-> s_pd_near(pd_ref_o[0]);
	endproperty
	a_main_start: assert property (p_main_start)
		else $error("main speed-up rose off a pulse");
	property p_main_end;
		$fell(speedup_o[0]) && power_en_o[0] |-> s_pd_near(pd_ref_o[0]);
	endproperty
	a_main_end: assert property (p_main_end)
		else $error("main speed-up fell off a pulse");
	property p_aux_start;
		$rose(speedup_o[1]) |-> s_pd_near(pd_ref_o[1]);
	endproperty
	a_aux_start: assert property (p_aux_start)
		else $error("aux speed-up rose off a pulse");
	property p_off_quiet;
		power_en_o == 3'h0 && $past(power_en_o, 2) == 3'h0
			|-> speedup_o == 3'h0;
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("speed-up with loops disabled");
endmodule

bind sfd_top sfd_chk u_chk (.clock_i(clock_i), .rstn_i(rstn_i),
	.ser_strobe_i(ser_strobe_i), .div_out_o(div_out_o),
	.pd_ref_o(pd_ref_o), .speedup_o(speedup_o), .power_en_o(power_en_o),
	.main_ratio_o(main_ratio_o), .aux_ratio_o(aux_ratio_o),
	.test_route_o(test_route_o));

// File: dv/sfd_host.sv
// serial host model: shifts 24-bit words lsb first, then strobes
// assumes the bench calls send_word; pins move after falling edges
`timescale 1ns/1ps
module sfd_host (
	input  wire logic clock_i,
	output logic      ser_clk_o,
	output logic      ser_data_o,
	output logic      ser_strobe_o
);
	////////////////////////////////////////
	// serial clock stands still low between words
	initial
	begin
		ser_clk_o = 1'b0;
		ser_data_o = 1'b1;
		ser_strobe_o = 1'b0;
	end

	// each level stands 4 clocks, a 400 ns serial period
	task automatic hold();
		repeat (4) @(negedge clock_i);
	endtask

	// whole word only; data line shows the inverse once released
	task automatic send_word(input logic [23:0] wd);
		for (int i = 0; i < 24; i++)
		begin
			ser_data_o = wd[i];
			hold();
			ser_clk_o = 1'b1;
			hold();
			ser_clk_o = 1'b0;
		end
		ser_data_o = ~wd[23];
		hold();
		ser_strobe_o = 1'b1;
		hold();
		ser_strobe_o = 1'b0;
		hold();
	endtask
endmodule

// File: dv/tb_top.sv
// self-checking bench: serial host, reference, prescalers, lock
// assumes the host model and the bound checker compile alongside
`timescale 1ns/1ps
module tb_top;
	logic        clock, rstn, ref_clk, s_clk, s_dat, s_stb, lko;
	logic [2:0]  presc, lock_in, modo, divo, pdo, spo, peno;
	logic [1:0]  mro, aro;
	logic [5:0]  tro;
	logic [21:0] w [4];
	logic [21:0] d;
	logic [31:0] e;
	logic [2:0]  ens [3];
	int          err_count, total_checks, seed, n, rc, pv, g, c;
	int          hi [3];
	int          mh [3];
	int          b [3];

	sfd_top DUT (.clock_i(clock), .rstn_i(rstn), .ser_clk_i(s_clk),
		.ser_data_i(s_dat), .ser_strobe_i(s_stb),
		.external_reference_oscillator_i(ref_clk), .prescaler_i(presc),
		.loop_lock_i(lock_in), .modulus_o(modo), .div_out_o(divo),
		.pd_ref_o(pdo), .speedup_o(spo), .power_en_o(peno),
		.main_ratio_o(mro), .aux_ratio_o(aro), .test_route_o(tro),
		.lock_indicator_output_o(lko));
	sfd_host host (.clock_i(clock), .ser_clk_o(s_clk), .ser_data_o(s_dat),
		.ser_strobe_o(s_stb));

	////////////////////////////////////////
	// 50 ns clock
	initial
	begin
		clock = 1'b0;
		forever
			#25 clock = ~clock;
	end

	// reference period 6 clocks; speed-up cycles tallied per loop
	always @(negedge clock)
	begin
		rc <= rc + 1;
		if (rc % 3 == 2)
			ref_clk <= ~ref_clk;
		if (rc % 4 == 3)
			presc <= ~presc;
		for (int i = 0; i < 3; i++)
		begin
			hi[i] <= hi[i] + int'(spo[i] === 1'b1);
			mh[i] <= mh[i] + int'(modo[i] === 1'b1);
		end
	end

	////////////////////////////////////////
	task automatic final_report();
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] x,
		input logic [31:0] y);
		total_checks++;
		if (y !== x)
		begin
			$display("unexpected %s expected %h seen %h", nm, x, y);
			err_count++;
		end
	endtask

	// lock select: AND term ignores disabled loops, false if none on
	function automatic logic [31:0] exp_lock(logic [1:0] s, logic [2:0] l,
		logic [2:0] en);
		if (s == 2'h3)
			return 32'(&(l | ~en) & |en);
		return 32'(l[s]);
	endfunction

	// pd period in clocks: 6 per reference, times divider and post
	function automatic int tp(int lp);
		return 6 * pv * (1 << w[2][16 + 2 * lp +: 2]);
	endfunction

	function automatic logic smp(int k, int lp);
		return (k == 2) ? divo[lp] : k ? spo[lp] : pdo[lp];
	endfunction

	// counts clocks until the picked output reaches lvl, bounded
	task automatic run_len(input int k, input int lp, input logic lvl);
		n = 0;
		while (smp(k, lp) !== lvl)
		begin
			@(negedge clock);
			n++;
			if (n > 3000)
			begin
				err_count++;
				final_report();
			end
		end
	endtask

	task automatic statics();
		check("power_en", 32'(w[3][13:11]), 32'(peno));
		check("main_ratio", 32'(w[1][15:14]), 32'(mro));
		check("aux_ratio", 32'(w[2][15:14]), 32'(aro));
		check("test_route", 32'(w[3][21:16]), 32'(tro));
	endtask

	// output update lands 4 clocks after the strobe; 8 leaves margin
	task automatic put(input logic [1:0] a, input logic [21:0] v);
		host.send_word({a, v});
		w[a] = v;
		repeat (8) @(negedge clock);
		statics();
	endtask

	task automatic spd(input int lp, input int dur);
		run_len(1, lp, 1'b1);
		run_len(1, lp, 1'b0);
		check("speedup", 32'(2 * dur * tp(lp)), 32'(hi[lp] - b[lp]));
	endtask

	// first gaps after a change may be short, so measure the third
	task automatic period(input int lp);
		repeat (2)
		begin
			run_len(0, lp, 1'b1);
			@(negedge clock);
		end
		run_len(0, lp, 1'b1);
		check("pd_period", 32'(tp(lp)), 32'(n + 1));
	endtask

	// bench prescaler edges every 8 clocks: n edges per divide,
	// swallow edges at high modulus; one whole cycle is measured
	task automatic divchk(input int lp, input int nv, input int av);
		int m;
		repeat (2)
		begin
			run_len(2, lp, 1'b1);
			@(negedge clock);
		end
		run_len(2, lp, 1'b1);
		m = mh[lp];
		@(negedge clock);
		run_len(2, lp, 1'b1);
		check("div_period", 32'(8 * nv), 32'(n + 1));
		check("swallow", 32'(8 * av), 32'(mh[lp] - m));
	endtask

	task automatic lockchk(input logic [1:0] s);
		for (int i = 0; i < 3; i++)
		begin
			lock_in = 3'($random(seed));
			repeat (6) @(negedge clock);
			e = exp_lock(s, lock_in, w[3][13:11]);
			check("lock", e, 32'(lko));
		end
	endtask

	////////////////////////////////////////
	initial
	begin
		seed = 61;
		{rstn, ref_clk, presc, lock_in, rc, err_count, total_checks} = '0;
		hi = '{0, 0, 0};
		mh = '{0, 0, 0};
		ens = '{3'h0, 3'h2, 3'h5};
		pv = 3;
		for (int i = 0; i < 4; i++)
			w[i] = 22'h0;
		repeat (8) @(negedge clock);
		rstn = 1'b1;
		repeat (2) @(negedge clock);
		statics();
		// small counters keep divides short, never below the swallow
		g = 1 + ($random(seed) & 3);
		d = 22'($random(seed));
		d[21:16] = 6'(g);
		d[13:3] = 11'(7 + ($random(seed) & 7));
		put(2'h1, d);
		d = 22'($random(seed));
		d[21:16] = 6'h24;
		d[13:3] = 11'(7 + ($random(seed) & 7));
		put(2'h2, d);
		b = hi;
		put(2'h3, {6'h2a, 2'h3, 3'h7, 11'(pv)});
		spd(1, g);
		spd(2, g);
		c = 1 + ($random(seed) & 3);
		d = 22'($random(seed));
		d[21:16] = 6'(c);
		d[15:5] = 11'(31 + ($random(seed) & 15));
		b = hi;
		put(2'h0, d);
		spd(0, c);
		for (int i = 0; i < 3; i++)
			period(i);
		d = w[2];
		d[17:16] = 2'h3;
		put(2'h2, d);
		period(0);
		divchk(0, int'(w[0][15:5]), int'(w[0][4:0]));
		divchk(1, int'(w[1][13:3]), int'(w[1][2:0]));
		divchk(2, int'(w[2][13:3]), int'(w[2][2:0]));
		b = hi;
		for (int s = 0; s < 4; s++)
		begin
			put(2'h3, {6'h15, 2'(s), 3'h7, 11'(pv)});
			lockchk(2'(s));
		end
		check("restart", 32'h0, 32'(hi[1] - b[1] + hi[2] - b[2]));
		for (int i = 0; i < 3; i++)
		begin
			put(2'h3, {6'h0, 2'h3, ens[i], 11'(pv)});
			lockchk(2'h3);
		end
		final_report();
	end
endmodule
